// ### rtl/mrom_bus_port.v
// Microprogram ROM on the shared precharged microinstruction bus
// Assumes the far side watches o_phase and drives address, chip select and
// the enable line during the matching phases; pin levels resolved outside
`include "mrom_map.vh"
`default_nettype none

module mrom_bus_port #(
   parameter [`MROM_WORD_W-1:0] ROM_SEED = `MROM_SEED_DEF,
   parameter [`MROM_WORD_W-1:0] CS_ROW = `MROM_CS_ROW_DEF,
   parameter [`MROM_WORD_W-1:0] OD_ROW = `MROM_OD_ROW_DEF,
   parameter [2:0] SEL_PAT = `MROM_SEL_PAT_DEF,
   parameter [2:0] SEL_CARE = `MROM_SEL_CARE_DEF
) (
   // Clock and reset
   input wire i_clk,
   input wire i_srst,
   // Pin inputs
   input wire [`MROM_ADDR_W-1:0] i_ad_line,
   input wire i_enable_line,
   input wire i_chip_sel,
   // Bus line drive
   output reg [`MROM_WORD_W-1:0] o_ubus_out,
   output reg [`MROM_WORD_W-1:0] o_ubus_oe,
   // Phase tracking
   output reg [1:0] o_phase,
   output reg o_phase_tick
);

////////////////////////////////////////////////////////////////////////////////
// Functions

// Select compare on {a10, a9, cs} against the programmed pattern
function sel_match;
   input [2:0] probe;
   begin
      sel_match = ((probe ^ SEL_PAT) & SEL_CARE) == 3'h0;
   end
endfunction

// Precharge lines for a phase code
function [`MROM_WORD_W-1:0] pre_mask;
   input [1:0] ph;
   begin
      case (ph)
         `MROM_PH1: pre_mask = `MROM_PRE_PH1;
         `MROM_PH2: pre_mask = `MROM_PRE_PH2;
         `MROM_PH3: pre_mask = `MROM_PRE_PH3;
         `MROM_PH4: pre_mask = `MROM_PRE_PH4;
         default: pre_mask = `MROM_PRE_PH1;
      endcase
   end
endfunction

// Default array contents, shaped by ROM_SEED
function [`MROM_WORD_W-1:0] rom_word;
   input [`MROM_IDX_W-1:0] idx;
   begin
      rom_word = {idx, ~idx, idx[3:0]} ^ ROM_SEED;
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Array

// Last count of a phase, eight system clocks per phase
localparam [`MROM_CNT_W-1:0] PHASE_LAST = 4'h7;

reg [`MROM_WORD_W-1:0] rom_mem [0:`MROM_WORDS-1];
integer k;

// Logic one per stored bit; a programmed transistor is a stored zero
initial begin
   for (k = 0; k < `MROM_WORDS; k = k + 1) begin
      rom_mem[k] = rom_word(k[`MROM_IDX_W-1:0]);
   end
end

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers

reg [`MROM_ADDR_W+1:0] in_s1_q;
reg [`MROM_ADDR_W+1:0] in_s2_q;
wire [`MROM_ADDR_W-1:0] ad_line_s;
wire enable_line_s;
wire chip_sel_s;

always @(posedge i_clk) begin
   if (i_srst) begin
      in_s1_q <= {(`MROM_ADDR_W+2){1'b1}};
      in_s2_q <= {(`MROM_ADDR_W+2){1'b1}};
   end else begin
      in_s1_q <= {i_chip_sel, i_enable_line, i_ad_line};
      in_s2_q <= in_s1_q;
   end
end

assign ad_line_s = in_s2_q[`MROM_ADDR_W-1:0];
assign enable_line_s = in_s2_q[`MROM_ADDR_W];
assign chip_sel_s = in_s2_q[`MROM_ADDR_W+1];

////////////////////////////////////////////////////////////////////////////////
// Phase tracking

reg [`MROM_CNT_W-1:0] cnt_q;
reg [`MROM_CNT_W-1:0] cnt_d;
reg [1:0] phase_q;
reg [1:0] phase_d;
wire phase_end;

assign phase_end = (cnt_q == PHASE_LAST);

always @* begin
   if (phase_end) begin
      cnt_d = {`MROM_CNT_W{1'b0}};
      phase_d = phase_q + 2'h1;
   end else begin
      cnt_d = cnt_q + {{(`MROM_CNT_W-1){1'b0}}, 1'b1};
      phase_d = phase_q;
   end
end

// Phases follow one another, only one active at a time
always @(posedge i_clk) begin
   if (i_srst) begin
      cnt_q <= {`MROM_CNT_W{1'b0}};
      phase_q <= `MROM_PH1;
   end else begin
      cnt_q <= cnt_d;
      phase_q <= phase_d;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Access pipeline

reg [`MROM_ADDR_W-1:0] addr_q;
reg cs_q;
reg sel_q;
reg od_q;
reg [`MROM_WORD_W-1:0] word_q;
reg [`MROM_WORD_W-1:0] word_d;
reg [`MROM_ADDR_W-1:0] addr_d;
reg cs_d;
reg sel_d;
reg od_d;

always @* begin
   addr_d = addr_q;
   cs_d = cs_q;
   sel_d = sel_q;
   od_d = od_q;
   word_d = word_q;
   if (phase_end) begin
      case (phase_q)
         `MROM_PH2: begin
            // Low line is a logic one
            addr_d = ~ad_line_s;
            cs_d = chip_sel_s;
         end
         `MROM_PH3: begin
            sel_d = sel_match({addr_q[`MROM_ADDR_BIT10], addr_q[`MROM_ADDR_BIT9], cs_q});
            od_d = ~enable_line_s;
         end
         `MROM_PH4: begin
            word_d = rom_mem[addr_q[`MROM_IDX_W-1:0]];
         end
         `MROM_PH1: begin
            word_d = word_q;
         end
         default: begin
            word_d = word_q;
         end
      endcase
   end
end

always @(posedge i_clk) begin
   if (i_srst) begin
      addr_q <= {`MROM_ADDR_W{1'b0}};
      cs_q <= 1'b0;
      sel_q <= 1'b0;
      od_q <= 1'b1;
      word_q <= {`MROM_WORD_W{1'b0}};
   end else begin
      addr_q <= addr_d;
      cs_q <= cs_d;
      sel_q <= sel_d;
      od_q <= od_d;
      word_q <= word_d;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Line drive

reg [`MROM_WORD_W-1:0] ext_low_q;
wire [`MROM_WORD_W-1:0] pre_nxt;
wire [`MROM_WORD_W-1:0] blk_nxt;
wire [`MROM_WORD_W-1:0] dis_nxt;
wire [`MROM_WORD_W-1:0] ext_low_d;
wire [`MROM_WORD_W-1:0] line_out_d;
wire [`MROM_WORD_W-1:0] line_oe_d;
wire enter_ph1;
wire in_ph1_d;

// Lines are registered against the phase the counter is entering
assign enter_ph1 = phase_end && (phase_q == `MROM_PH4);
assign in_ph1_d = (phase_d == `MROM_PH1);

// Precharge does not look at selection
assign pre_nxt = pre_mask(phase_d);

// Deselect and output disable act on the lines their rows name
assign blk_nxt = ({`MROM_WORD_W{~sel_d}} & CS_ROW) | ({`MROM_WORD_W{od_d}} & OD_ROW);

assign dis_nxt = {`MROM_WORD_W{in_ph1_d}} & word_d & ~blk_nxt;

// External lines keep their low from phase one through phase three
assign ext_low_d = (phase_d == `MROM_PH4) ? {`MROM_WORD_W{1'b0}} :
   (enter_ph1 ? (dis_nxt & `MROM_EXT_MASK) : ext_low_q);

genvar b;
generate
   for (b = 0; b < `MROM_WORD_W; b = b + 1) begin : g_line
      // Discharge wins over hold, hold wins over release
      assign line_out_d[b] = pre_nxt[b] & ~dis_nxt[b] & ~ext_low_d[b];
      assign line_oe_d[b] = pre_nxt[b] | dis_nxt[b] | ext_low_d[b];
   end
endgenerate

always @(posedge i_clk) begin
   if (i_srst) begin
      ext_low_q <= {`MROM_WORD_W{1'b0}};
      o_ubus_out <= {`MROM_WORD_W{1'b0}};
      o_ubus_oe <= {`MROM_WORD_W{1'b0}};
      o_phase <= `MROM_PH1;
      o_phase_tick <= 1'b0;
   end else begin
      ext_low_q <= ext_low_d;
      o_ubus_out <= line_out_d;
      o_ubus_oe <= line_oe_d;
      o_phase <= phase_d;
      o_phase_tick <= phase_end;
   end
end

endmodule // mrom_bus_port

`default_nettype wire

// ### rtl/mrom_map.vh
// Constants for the microprogram ROM bus port: phases, line positions, masks
// Assumes a single 100 MHz system clock; the four bus phases are derived from it
`ifndef MROM_MAP_VH
`define MROM_MAP_VH

// Timing
`define MROM_CLK_NS 10
`define MROM_PHASE_NS 80
`define MROM_PHASE_CYC (`MROM_PHASE_NS / `MROM_CLK_NS)
`define MROM_CNT_W 4

// Phase codes
`define MROM_PH1 2'h0
`define MROM_PH2 2'h1
`define MROM_PH3 2'h2
`define MROM_PH4 2'h3

// Array geometry
`define MROM_WORDS 512
`define MROM_WORD_W 22
`define MROM_IDX_W 9
`define MROM_ADDR_W 11

// Line positions
`define MROM_ADDR_BIT9 9
`define MROM_ADDR_BIT10 10
`define MROM_LINE_ENABLE 16
`define MROM_LINE_NEXT 17
`define MROM_EXT_LO 18
`define MROM_EXT_HI 21

// Precharge masks per phase
`define MROM_PRE_PH1 22'h000000
`define MROM_PRE_PH2 22'h010000
`define MROM_PRE_PH3 22'h008000
`define MROM_PRE_PH4 22'h3f7fff
`define MROM_EXT_MASK 22'h3c0000

// Programmable rows and select pattern defaults
`define MROM_CS_ROW_DEF 22'h3fffff
`define MROM_OD_ROW_DEF 22'h3cffff
`define MROM_SEL_PAT_DEF 3'h1
`define MROM_SEL_CARE_DEF 3'h7
`define MROM_SEED_DEF 22'h15a3c7

`endif

// ### verif/mrom_checker.sv
// Checker for the ROM bus port: phase sequence and per-phase line drive
// Assumes it is bound onto mrom_bus_port; phase codes 0..3 are ph1..ph4
`default_nettype none
module mrom_chk (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Watched outputs
   input wire logic [21:0] o_ubus_out,
   input wire logic [21:0] o_ubus_oe,
   input wire logic [1:0] o_phase,
   input wire logic o_phase_tick
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   a_phase_order: assert property ($changed(o_phase) |-> o_phase == $past(o_phase) + 2'h1)
      else $error("phase order broken");
   a_tick_marks: assert property (o_phase_tick == $changed(o_phase))
      else $error("tick not at phase change");
   a_phase_len: assert property ($rose(o_phase_tick) |=> !o_phase_tick [*7] ##1 o_phase_tick)
      else $error("phase not eight cycles");
   a_line16_pre: assert property (o_phase == 2'h1 |-> (o_ubus_oe & 22'h03ffff) == 22'h010000 && o_ubus_out[16])
      else $error("ph2 drive wrong");
   a_line15_pre: assert property (o_phase == 2'h2 |-> (o_ubus_oe & 22'h03ffff) == 22'h008000 && o_ubus_out[15])
      else $error("ph3 drive wrong");
   a_ph4_pre: assert property (o_phase == 2'h3 |-> o_ubus_oe == 22'h3f7fff && (o_ubus_out & 22'h3f7fff) == 22'h3f7fff)
      else $error("ph4 precharge wrong");
   a_ph1_low: assert property (o_phase == 2'h0 |-> (o_ubus_out & o_ubus_oe) == 22'h0)
      else $error("ph1 drives high");
   a_ext_hold: assert property (o_phase_tick && ^o_phase |-> $stable(o_ubus_oe[21:18]) && (o_ubus_out[21:18] & o_ubus_oe[21:18]) == 4'h0)
      else $error("external low not held");
endmodule // mrom_chk
bind mrom_bus_port mrom_chk mrom_chk_inst (.i_clk(i_clk), .i_srst(i_srst), .o_ubus_out(o_ubus_out),
   .o_ubus_oe(o_ubus_oe), .o_phase(o_phase), .o_phase_tick(o_phase_tick));
`default_nettype wire

// ### verif/mrom_ctl_model.sv
// Control chip model: drives address and enable line, fetches the word
// Assumes released bus lines are pulled high
`default_nettype none
module mrom_ctl_model (
   // Clock and ROM outputs
   input wire logic i_clk,
   input wire logic [1:0] i_phase,
   input wire logic [21:0] i_ubus_out,
   input wire logic [21:0] i_ubus_oe,
   // Bench commands
   input wire logic [10:0] i_addr,
   input wire logic i_sel,
   input wire logic i_od,
   // Pin levels to the ROM
   output logic [10:0] o_ad_line,
   output logic o_enable_line,
   output logic o_chip_sel,
   // Fetched word and strobes
   output logic [21:0] o_word,
   output logic o_load_return_strobe,
   output logic o_next_instruction
);
   logic [21:0] line;
   always_comb begin
      line = i_ubus_out | ~i_ubus_oe;
      if (i_phase == 2'h1) line[10:0] = ~i_addr;
      if (i_phase == 2'h2 && i_od) line[16] = 1'b0;
   end
   assign o_ad_line = line[10:0];
   assign o_enable_line = line[16];
   assign o_chip_sel = (i_phase == 2'h1) ? i_sel : ~i_sel;
   always @(posedge i_clk) begin
      if (i_phase == 2'h0) begin
         o_word <= ~line;
         o_load_return_strobe <= ~line[16];
         o_next_instruction <= ~line[17];
      end
   end
endmodule // mrom_ctl_model
`default_nettype wire

// ### verif/microprogram_rom_bus_port_tb.sv
// Bench for the ROM bus port: reads, deselects, output disable, reset
// Assumes default parameters and the control chip model beside it
`include "mrom_map.vh"
`default_nettype none
module microprogram_rom_bus_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 0, i_srst = 1, sel = 0, od = 0, ld, nx, en, cs, tick;
   logic [10:0] addr = 0, ad;
   logic [21:0] bout, boe, word;
   logic [1:0] ph;
   int fails = 0, checks_done = 0;
   always #5 i_clk = ~i_clk;
   mrom_bus_port mrom_bus_port_inst (.i_clk(i_clk), .i_srst(i_srst), .i_ad_line(ad), .i_enable_line(en),
      .i_chip_sel(cs), .o_ubus_out(bout), .o_ubus_oe(boe), .o_phase(ph), .o_phase_tick(tick));
   mrom_ctl_model mrom_ctl_model_inst (.i_clk(i_clk), .i_phase(ph), .i_ubus_out(bout), .i_ubus_oe(boe),
      .i_addr(addr), .i_sel(sel), .i_od(od), .o_ad_line(ad), .o_enable_line(en), .o_chip_sel(cs),
      .o_word(word), .o_load_return_strobe(ld), .o_next_instruction(nx));
   function automatic logic [21:0] rom(input logic [8:0] i);
      return {i, ~i, i[3:0]} ^ `MROM_SEED_DEF;
   endfunction
   task automatic check(input logic [21:0] seen, input logic [21:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wait_ph(input logic [1:0] p);
      int n;
      n = 0;
      while (!(tick === 1'b1 && ph === p)) begin
         @(posedge i_clk);
         #1;
         n++;
         if (n > 100) begin
            fails++;
            close_out();
         end
      end
   endtask
   // Command in ph2, judge the fetched word once ph1 is over
   task automatic fetch(input logic [10:0] a, input logic s, input logic o, input logic [21:0] exp);
      wait_ph(2'h1);
      addr = a;
      sel = s;
      od = o;
      wait_ph(2'h0);
      wait_ph(2'h1);
      check(word, exp);
      check({20'h0, nx, ld}, {20'h0, exp[17], exp[16]});
   endtask
   task automatic scen_reads;
      fetch(11'h000, 1, 0, rom(9'h000));
      fetch(11'h1ff, 1, 0, rom(9'h1ff));
      fetch(11'h0a5, 1, 0, rom(9'h0a5));
   endtask
   task automatic scen_desel;
      fetch(11'h005, 0, 0, 22'h0);
      fetch(11'h205, 1, 0, 22'h0);
      fetch(11'h405, 1, 0, 22'h0);
      fetch(11'h05a, 1, 0, rom(9'h05a));
   endtask
   task automatic scen_od;
      fetch(11'h0f3, 1, 1, rom(9'h0f3) & ~`MROM_OD_ROW_DEF);
      fetch(11'h0f3, 1, 0, rom(9'h0f3));
   endtask
   task automatic scen_reset;
      i_srst = 1;
      repeat (3) @(posedge i_clk);
      #1;
      check(boe, 22'h0);
      check({20'h0, ph}, 22'h0);
      i_srst = 0;
      fetch(11'h13c, 1, 0, rom(9'h13c));
   endtask
   initial begin
      repeat (10) @(posedge i_clk);
      #1 i_srst = 0;
      scen_reads();
      scen_desel();
      scen_od();
      scen_reset();
      close_out();
   end
endmodule // microprogram_rom_bus_port_tb
`default_nettype wire
